// file: src/cec_core.sv
// Operation
// - 16-bit data path; program and data memories on separate ports.
// - instructions are 24-bit words with a fixed 4-bit opcode field.
// - program counter is 23 bits, addressing 4M instruction words.
// - next instruction is fetched one cycle ahead of execution.
// - one cycle per instruction except flow change, double move, table.
// - block and single-instruction loops with no overhead, interruptible.
// - sixteen 16-bit working registers usable as data, address, offset.
// - register fifteen is the stack pointer for calls and interrupts.
// - data read, register read, data write and fetch in one cycle.
// - decoder runs general and signal-processing classes in one pipe.
`timescale 1ns/10ps
`default_nettype none
module cec_core
  import cec_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // program memory
  output logic [PC_W-1:0]        pm_addr,
  input  wire logic [INSTR_W-1:0] pm_rdata,
  // data memory read
  output logic                   dm_re,
  output logic [DATA_W-1:0]      dm_raddr,
  input  wire logic [DATA_W-1:0] dm_rdata,
  // data memory write
  output logic                   dm_we,
  output logic [DATA_W-1:0]      dm_waddr,
  output logic [DATA_W-1:0]      dm_wdata,
  // interrupt
  input  wire logic              irq_req,
  output logic                   irq_ack,
  output logic                   in_isr
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ST_EXEC, ST_MOVD2, ST_TBL, ST_PUSH_HI, ST_POP_LO
  } cec_state_t;

  cec_state_t        state_q, state_d;
  logic [PC_W-1:0]   pc_q;
  cec_instr_t        ir_q;
  logic [PC_W-1:0]   ir_pc_q;
  logic              ir_valid_q;
  logic              ir_looped_q;
  logic [6:0]        ret_hi_q, ret_hi_d;
  logic [PC_W-1:0]   tgt_q, tgt_d;
  logic              retfie_q, retfie_d;
  logic [DATA_W-1:0] rpt_q;
  logic [DATA_W-1:0] rpt_save_q;
  logic [9:0]        do_cnt_q;
  logic [PC_W-1:0]   do_start_q;
  logic [PC_W-1:0]   do_end_q;
  logic              isr_q;

  logic              fetch_go, redirect, take_irq;
  logic              rpt_set, rpt_dec, do_set, do_restore, isr_clr;
  logic [PC_W-1:0]   redir_pc, seq_pc, ret_pc;
  logic              loop_back;
  logic              do_hit;
  logic              do_live;
  logic [9:0]        do_new_cnt;
  logic [PC_W-1:0]   do_new_end;
  logic [31:0]       prod;

  cec_rf_if rfi ();

  cec_regfile u_rf (
    .ref_clk (ref_clk),
    .reset   (reset),
    .rf      (rfi.rf)
  );

  // ==========================================================
  // fetch address and register read selection
  assign do_new_cnt = {ir_q.sub, ir_q.wd, ir_q.wa[3:2]};
  assign do_new_end = pc_rel(ir_pc_q, {10'h000, ir_q.wa[1:0], ir_q.wb,
                                       ir_q.lo});
  // loop set up in the same cycle as the fetch of its end
  assign do_hit    = do_set ? (pc_q == do_new_end) : (pc_q == do_end_q);
  assign do_live   = do_set ? (do_new_cnt != DO_RESET)
                            : (do_cnt_q != DO_RESET);
  assign loop_back = do_live && do_hit;
  assign seq_pc    = !loop_back ? pc_q + PC_STEP
                   : do_set ? ir_pc_q + PC_STEP : do_start_q;
  assign rfi.ra    = ir_q.wa;
  assign rfi.rb    = ir_q.wb;
  assign rfi.rc    = ir_q.wd;
  assign prod      = rfi.da * rfi.db;
  assign take_irq  = irq_req && !isr_q && ir_valid_q
                     && (state_q == ST_EXEC);
  assign ret_pc    = take_irq ? ir_pc_q : ir_pc_q + PC_STEP;
  assign irq_ack   = take_irq;
  assign in_isr    = isr_q;

  // ==========================================================
  // decode and execute
  always_comb begin
    state_d     = state_q;
    fetch_go    = 1'b0;
    redirect    = 1'b0;
    redir_pc    = pc_q;
    pm_addr     = pc_q;
    dm_re       = 1'b0;
    dm_raddr    = rfi.da;
    dm_we       = 1'b0;
    dm_waddr    = rfi.sp;
    dm_wdata    = '0;
    rfi.we      = 1'b0;
    rfi.waddr   = ir_q.wd;
    rfi.wdata   = '0;
    ret_hi_d    = ret_hi_q;
    tgt_d       = tgt_q;
    retfie_d    = retfie_q;
    rpt_set     = 1'b0;
    rpt_dec     = 1'b0;
    do_set      = 1'b0;
    do_restore  = 1'b0;
    isr_clr     = 1'b0;
    case (state_q)
      ST_EXEC: begin
        if (!ir_valid_q) begin
          fetch_go = 1'b1;
        end else if (take_irq) begin
          // abandon current instruction, push its address
          do_restore = ir_looped_q;
          dm_we      = 1'b1;
          dm_wdata   = ret_pc[15:0];
          rfi.we     = 1'b1;
          rfi.waddr  = SP_IDX;
          rfi.wdata  = rfi.sp + WORD_STEP;
          ret_hi_d   = ret_pc[22:16];
          tgt_d      = IRQ_VECTOR;
          state_d    = ST_PUSH_HI;
        end else begin
          fetch_go = (rpt_q == RPT_RESET);
          rpt_dec  = (rpt_q != RPT_RESET);
          case (ir_q.op)
            OP_ALU: begin
              rfi.we    = 1'b1;
              rfi.wdata = alu_op(ir_q.sub, rfi.da, rfi.db);
            end
            OP_MOVL: begin
              rfi.waddr = ir_q.sub;
              rfi.we    = 1'b1;
              rfi.wdata = {ir_q.wd, ir_q.wa, ir_q.wb, ir_q.lo};
            end
            OP_LOAD: begin
              dm_re     = 1'b1;
              dm_raddr  = rfi.da + rfi.db;
              rfi.we    = 1'b1;
              rfi.wdata = dm_rdata;
            end
            OP_STORE: begin
              dm_we    = 1'b1;
              dm_waddr = rfi.da + rfi.db;
              dm_wdata = rfi.dc;
            end
            OP_ADDM: begin
              dm_re    = 1'b1;
              dm_we    = 1'b1;
              dm_waddr = rfi.dc;
              dm_wdata = dm_rdata + rfi.db;
            end
            OP_DSP: begin
              rfi.we = 1'b1;
              case (ir_q.sub)
                DSP_MAC: rfi.wdata = rfi.dc + prod[15:0];
                DSP_MSC: rfi.wdata = rfi.dc - prod[15:0];
                default: rfi.wdata = prod[15:0];
              endcase
            end
            OP_GOTO: begin
              redirect = 1'b1;
              fetch_go = 1'b0;
              rpt_dec  = 1'b0;
              redir_pc = pc_rel(ir_pc_q, {ir_q.sub, ir_q.wd, ir_q.wa,
                                          ir_q.wb, ir_q.lo});
            end
            OP_CALL: begin
              fetch_go  = 1'b0;
              rpt_dec   = 1'b0;
              dm_we     = 1'b1;
              dm_wdata  = ret_pc[15:0];
              rfi.we    = 1'b1;
              rfi.waddr = SP_IDX;
              rfi.wdata = rfi.sp + WORD_STEP;
              ret_hi_d  = ret_pc[22:16];
              tgt_d     = pc_rel(ir_pc_q, {ir_q.sub, ir_q.wd, ir_q.wa,
                                           ir_q.wb, ir_q.lo});
              state_d   = ST_PUSH_HI;
            end
            OP_RET: begin
              fetch_go  = 1'b0;
              rpt_dec   = 1'b0;
              dm_re     = 1'b1;
              dm_raddr  = rfi.sp - WORD_STEP;
              rfi.we    = 1'b1;
              rfi.waddr = SP_IDX;
              rfi.wdata = rfi.sp - WORD_STEP;
              ret_hi_d  = dm_rdata[6:0];
              retfie_d  = (ir_q.sub == RET_ISR);
              state_d   = ST_POP_LO;
            end
            OP_DO: do_set = 1'b1;
            OP_REPEAT: begin
              rpt_set = 1'b1;
              rpt_dec = 1'b0;
            end
            OP_MOVD: begin
              fetch_go  = 1'b0;
              rpt_dec   = 1'b0;
              dm_re     = 1'b1;
              rfi.waddr = {ir_q.wd[3:1], 1'b0};
              rfi.we    = 1'b1;
              rfi.wdata = dm_rdata;
              state_d   = ST_MOVD2;
            end
            OP_TBLRD: begin
              fetch_go = 1'b0;
              rpt_dec  = 1'b0;
              state_d  = ST_TBL;
            end
            default: ;
          endcase
        end
      end
      ST_MOVD2: begin
        fetch_go  = 1'b1;
        dm_re     = 1'b1;
        dm_raddr  = rfi.da + WORD_STEP;
        rfi.waddr = {ir_q.wd[3:1], 1'b1};
        rfi.we    = 1'b1;
        rfi.wdata = dm_rdata;
        state_d   = ST_EXEC;
      end
      ST_TBL: begin
        pm_addr   = {7'h00, rfi.da};
        rfi.we    = 1'b1;
        rfi.wdata = pm_rdata[15:0];
        redirect  = 1'b1;
        redir_pc  = pc_q;
        state_d   = ST_EXEC;
      end
      ST_PUSH_HI: begin
        dm_we     = 1'b1;
        dm_wdata  = {9'h000, ret_hi_q};
        rfi.we    = 1'b1;
        rfi.waddr = SP_IDX;
        rfi.wdata = rfi.sp + WORD_STEP;
        redirect  = 1'b1;
        redir_pc  = tgt_q;
        state_d   = ST_EXEC;
      end
      ST_POP_LO: begin
        dm_re     = 1'b1;
        dm_raddr  = rfi.sp - WORD_STEP;
        rfi.we    = 1'b1;
        rfi.waddr = SP_IDX;
        rfi.wdata = rfi.sp - WORD_STEP;
        redirect  = 1'b1;
        redir_pc  = {ret_hi_q, dm_rdata};
        isr_clr   = retfie_q;
        state_d   = ST_EXEC;
      end
      default: state_d = ST_EXEC;
    endcase
  end

  // ==========================================================
  // sequencer state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q  <= ST_EXEC;
      ret_hi_q <= '0;
      tgt_q    <= RESET_PC;
      retfie_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      ret_hi_q <= ret_hi_d;
      tgt_q    <= tgt_d;
      retfie_q <= retfie_d;
    end
  end

  // ==========================================================
  // program counter and prefetch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_q <= RESET_PC;
    end else if (redirect) begin
      pc_q <= redir_pc;
    end else if (fetch_go) begin
      pc_q <= seq_pc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ir_q        <= '0;
      ir_pc_q     <= RESET_PC;
      ir_valid_q  <= 1'b0;
      ir_looped_q <= 1'b0;
    end else if (redirect || take_irq) begin
      ir_valid_q  <= 1'b0;
    end else if (fetch_go) begin
      ir_q        <= pm_rdata;
      ir_pc_q     <= pc_q;
      ir_valid_q  <= 1'b1;
      ir_looped_q <= loop_back;
    end
  end

  // ==========================================================
  // loop counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rpt_q      <= RPT_RESET;
      rpt_save_q <= RPT_RESET;
    end else if (take_irq) begin
      rpt_save_q <= rpt_q;
      rpt_q      <= RPT_RESET;
    end else if (isr_clr) begin
      rpt_q      <= rpt_save_q;
    end else if (rpt_set) begin
      rpt_q <= {ir_q.wd, ir_q.wa, ir_q.wb, ir_q.lo};
    end else if (rpt_dec) begin
      rpt_q <= rpt_q - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      do_cnt_q   <= DO_RESET;
      do_start_q <= RESET_PC;
      do_end_q   <= RESET_PC;
    end else if (do_set) begin
      do_cnt_q   <= (fetch_go && loop_back) ? do_new_cnt - 10'h001
                                            : do_new_cnt;
      do_start_q <= ir_pc_q + PC_STEP;
      do_end_q   <= do_new_end;
    end else if (do_restore) begin
      do_cnt_q   <= do_cnt_q + 10'h001;
    end else if (fetch_go && loop_back) begin
      do_cnt_q   <= do_cnt_q - 10'h001;
    end
  end

  // ==========================================================
  // interrupt nesting flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      isr_q <= 1'b0;
    end else if (take_irq) begin
      isr_q <= 1'b1;
    end else if (isr_clr) begin
      isr_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: src/cec_pkg.sv
package cec_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W  = 16;
  localparam int INSTR_W = 24;
  localparam int PC_W    = 23;
  localparam int NUM_W   = 16;

  // ==========================================================
  // reset values and steps
  localparam logic [PC_W-1:0]   RESET_PC    = 23'h000000;
  localparam logic [PC_W-1:0]   IRQ_VECTOR  = 23'h000004;
  localparam logic [PC_W-1:0]   PC_STEP     = 23'h000002;
  localparam logic [DATA_W-1:0] WORD_STEP   = 16'h0002;
  localparam logic [DATA_W-1:0] SP_RESET    = 16'h0800;
  localparam logic [3:0]        SP_IDX      = 4'hf;
  localparam logic [DATA_W-1:0] RPT_RESET   = 16'h0000;
  localparam logic [9:0]        DO_RESET    = 10'h000;

  // ==========================================================
  // major opcodes
  localparam logic [3:0] OP_NOP    = 4'h0;
  localparam logic [3:0] OP_ALU    = 4'h1;
  localparam logic [3:0] OP_MOVL   = 4'h2;
  localparam logic [3:0] OP_LOAD   = 4'h3;
  localparam logic [3:0] OP_STORE  = 4'h4;
  localparam logic [3:0] OP_ADDM   = 4'h5;
  localparam logic [3:0] OP_DSP    = 4'h6;
  localparam logic [3:0] OP_GOTO   = 4'h7;
  localparam logic [3:0] OP_CALL   = 4'h8;
  localparam logic [3:0] OP_RET    = 4'h9;
  localparam logic [3:0] OP_DO     = 4'ha;
  localparam logic [3:0] OP_REPEAT = 4'hb;
  localparam logic [3:0] OP_MOVD   = 4'hc;
  localparam logic [3:0] OP_TBLRD  = 4'hd;

  // sub codes
  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_SUB = 4'h1;
  localparam logic [3:0] ALU_AND = 4'h2;
  localparam logic [3:0] ALU_OR  = 4'h3;
  localparam logic [3:0] ALU_XOR = 4'h4;
  localparam logic [3:0] ALU_MOV = 4'h5;
  localparam logic [3:0] DSP_MAC = 4'h0;
  localparam logic [3:0] DSP_MSC = 4'h1;
  localparam logic [3:0] DSP_MUL = 4'h2;
  localparam logic [3:0] RET_ISR = 4'h1;

  // ==========================================================
  // instruction word layout
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] sub;
    logic [3:0] wd;
    logic [3:0] wa;
    logic [3:0] wb;
    logic [3:0] lo;
  } cec_instr_t;

  function automatic logic [PC_W-1:0] pc_rel(input logic [PC_W-1:0] pc,
                                             input logic [19:0] off);
    pc_rel = pc + {{2{off[19]}}, off, 1'b0};
  endfunction

  function automatic logic [DATA_W-1:0] alu_op(input logic [3:0] f,
                                               input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] b);
    case (f)
      ALU_ADD: alu_op = a + b;
      ALU_SUB: alu_op = a - b;
      ALU_AND: alu_op = a & b;
      ALU_OR:  alu_op = a | b;
      ALU_XOR: alu_op = a ^ b;
      ALU_MOV: alu_op = a;
      default: alu_op = a;
    endcase
  endfunction

endpackage

// file: src/cec_rf_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cec_rf_if;
  logic [3:0]  ra;
  logic [3:0]  rb;
  logic [3:0]  rc;
  logic [15:0] da;
  logic [15:0] db;
  logic [15:0] dc;
  logic [15:0] sp;
  logic        we;
  logic [3:0]  waddr;
  logic [15:0] wdata;

  modport core (output ra, rb, rc, we, waddr, wdata,
                input  da, db, dc, sp);
  modport rf   (input  ra, rb, rc, we, waddr, wdata,
                output da, db, dc, sp);
endinterface
`default_nettype wire

// file: src/cec_regfile.sv
`timescale 1ns/10ps
`default_nettype none
module cec_regfile
  import cec_pkg::*;
#(
  parameter int NUM   = NUM_W,
  parameter int WIDTH = DATA_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  cec_rf_if.rf     rf
);

  // ==========================================================
  // storage
  logic [WIDTH-1:0] regs_q [NUM];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM; i++) begin
        regs_q[i] <= '0;
      end
      regs_q[SP_IDX] <= SP_RESET;
    end else if (rf.we) begin
      regs_q[rf.waddr] <= rf.wdata;
    end
  end

  // ==========================================================
  // read ports
  assign rf.da = regs_q[rf.ra];
  assign rf.db = regs_q[rf.rb];
  assign rf.dc = regs_q[rf.rc];
  assign rf.sp = regs_q[SP_IDX];

endmodule
`default_nettype wire

// file: testbench/cec_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// program and data memories
module cec_mem_model
  import cec_pkg::*;
(
  // clock
  input  wire logic              ref_clk,
  // program bus
  input  wire logic [PC_W-1:0]   pm_addr,
  output logic [INSTR_W-1:0]     pm_rdata,
  // data bus
  input  wire logic              dm_re,
  input  wire logic [DATA_W-1:0] dm_raddr,
  output logic [DATA_W-1:0]      dm_rdata,
  input  wire logic              dm_we,
  input  wire logic [DATA_W-1:0] dm_waddr,
  input  wire logic [DATA_W-1:0] dm_wdata
);
  logic [INSTR_W-1:0] pmem [256];
  logic [DATA_W-1:0]  dmem [2048];
  // own program path, one 24-bit word per even address
  assign pm_rdata = pmem[pm_addr[8:1]];
  // read beside write in one cycle, idle read shows the inverted read address
  assign dm_rdata = dm_re ? dmem[dm_raddr[11:1]] : ~dm_raddr;
  always @(posedge ref_clk) begin
    if (dm_we) begin
      dmem[dm_waddr[11:1]] <= dm_wdata;
    end
  end
endmodule
`default_nettype wire

// file: testbench/cec_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// core port checks
module cec_core_sva
  import cec_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // buses
  input wire logic [PC_W-1:0]   pm_addr,
  input wire logic              dm_re,
  input wire logic              dm_we,
  input wire logic [DATA_W-1:0] dm_waddr,
  input wire logic [DATA_W-1:0] dm_wdata,
  // interrupt
  input wire logic              irq_req,
  input wire logic              irq_ack,
  input wire logic              in_isr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_PM_EVEN: assert property (pm_addr[0] == 1'b0)
    else $error("odd program address");
  AST_RESET_FETCH: assert property (
    $fell(reset) |-> pm_addr == RESET_PC && !dm_we && !irq_ack
      ##1 pm_addr == RESET_PC + PC_STEP)
    else $error("first fetch after reset wrong");
  AST_ACK_CAUSE: assert property (irq_ack |-> irq_req && !in_isr)
    else $error("ack without request");
  AST_ACK_PULSE: assert property (irq_ack |=> !irq_ack)
    else $error("ack longer than one cycle");
  AST_ISR_SET: assert property (irq_ack |=> in_isr [*3])
    else $error("isr flag not held");
  AST_ISR_CAUSE: assert property ($rose(in_isr) |-> $past(irq_ack))
    else $error("isr flag without ack");
  AST_PUSH_PAIR: assert property (
    irq_ack |-> dm_we ##1 dm_we && dm_waddr == $past(dm_waddr) + WORD_STEP)
    else $error("return address push wrong");
  AST_PUSH_HIGH: assert property (
    irq_ack |=> dm_wdata[15:7] == 9'h000)
    else $error("high push wider than counter");
  AST_VECTOR: assert property (irq_ack |-> ##2 pm_addr == IRQ_VECTOR)
    else $error("vector not fetched");

  C_ACK: cover property (irq_ack);
  C_RW: cover property (dm_re && dm_we);
  C_RET: cover property ($fell(in_isr));
endmodule

bind cec_core cec_core_sva cec_core_sva_inst (.*);
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define PM cec_mem_model_inst.pmem
`define DM cec_mem_model_inst.dmem
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      errors++; \
      $display("wrong value %s exp %h got %h", nm, ex, got); \
    end \
  end
// ==========================================================
// core bench
module testbench
  import cec_pkg::*;
;
  // clock, reset, interrupt
  logic ref_clk;
  logic reset;
  logic irq_req;
  logic irq_ack;
  logic in_isr;
  // buses
  logic [PC_W-1:0]    pm_addr;
  logic [INSTR_W-1:0] pm_rdata;
  logic               dm_re;
  logic [DATA_W-1:0]  dm_raddr;
  logic [DATA_W-1:0]  dm_rdata;
  logic               dm_we;
  logic [DATA_W-1:0]  dm_waddr;
  logic [DATA_W-1:0]  dm_wdata;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int pi;

  cec_core cec_core_inst (.*);
  cec_mem_model cec_mem_model_inst (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end

  function automatic logic [23:0] iw(logic [3:0] op, logic [3:0] s,
                                     logic [3:0] d, logic [3:0] a,
                                     logic [3:0] b);
    return {op, s, d, a, b, 4'h0};
  endfunction
  task automatic put(logic [23:0] x);
    `PM[pi] = x;
    pi++;
  endtask
  task automatic start();
    reset = 1'b1;
    irq_req = 1'b0;
    @(negedge ref_clk);
    for (int i = 0; i < 256; i++) `PM[i] = 24'h000000;
    for (int i = 0; i < 2048; i++) `DM[i] = 16'h0000;
    pi = 0;
  endtask
  task automatic go();
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
  endtask

  // ========================================================
  // data operations
  task automatic t_alu();
    logic [15:0] e;
    start();
    put({OP_MOVL, 4'h1, 16'h1234});
    put({OP_MOVL, 4'h2, 16'h0f0f});
    put({OP_MOVL, 4'ha, 16'h0100});
    put({OP_MOVL, 4'hb, 16'h0002});
    put({OP_MOVL, 4'h4, 16'h0005});
    for (int f = 0; f < 9; f++) begin
      put(iw(f < 6 ? OP_ALU : OP_DSP, 4'(f % 6), f < 6 ? 4'h3 : 4'h4,
             f < 6 ? 4'h1 : 4'h2, f < 6 ? 4'h2 : 4'hb));
      put(iw(OP_STORE, 4'h0, f < 6 ? 4'h3 : 4'h4, 4'ha, 4'h0));
      put(iw(OP_ALU, ALU_ADD, 4'ha, 4'ha, 4'hb));
    end
    `DM[16'h0100] = 16'h1111;
    put({OP_MOVL, 4'hc, 16'h0300});
    put({OP_MOVL, 4'hd, 16'h0200});
    put(iw(OP_ADDM, 4'h0, 4'hc, 4'hd, 4'h2));
    put(iw(OP_LOAD, 4'h0, 4'h5, 4'hd, 4'h0));
    put(iw(OP_STORE, 4'h0, 4'h5, 4'ha, 4'h0));
    `DM[16'h0101] = 16'h2222;
    put(iw(OP_MOVD, 4'h0, 4'h6, 4'hd, 4'h0));
    put(iw(OP_STORE, 4'h0, 4'h7, 4'ha, 4'hb));
    put(iw(OP_STORE, 4'h0, 4'h6, 4'ha, 4'hc));
    go();
    for (int k = 0; k < 8; k++) begin
      `CHK("fetch address", 23'(2 * k), pm_addr)
      @(negedge ref_clk);
    end
    repeat (60) @(negedge ref_clk);
    for (int f = 0; f < 6; f++) begin
      case (f)
        0: e = 16'h1234 + 16'h0f0f;
        1: e = 16'h1234 - 16'h0f0f;
        2: e = 16'h1234 & 16'h0f0f;
        3: e = 16'h1234 | 16'h0f0f;
        4: e = 16'h1234 ^ 16'h0f0f;
        default: e = 16'h1234;
      endcase
      `CHK("alu result", e, `DM[8'h80 + f])
    end
    e = 16'h0005;
    for (int f = 0; f < 3; f++) begin
      e = f == 0 ? e + 16'h1e1e : f == 1 ? e - 16'h1e1e : 16'h1e1e;
      `CHK("dsp result", e, `DM[8'h86 + f])
    end
    `CHK("add to memory", 16'h2020, `DM[16'h0180])
    `CHK("load", 16'h1111, `DM[8'h89])
    `CHK("double move even", 16'h1111, `DM[16'h0209])
    `CHK("double move odd", 16'h2222, `DM[8'h8a])
    $display("test alu done");
  endtask

  // ========================================================
  // jumps, call, table read
  task automatic t_flow();
    start();
    put({OP_MOVL, 4'h1, 16'haaaa});
    put({OP_MOVL, 4'ha, 16'h0180});
    put({OP_MOVL, 4'hb, 16'h0002});
    put({OP_GOTO, 20'h00002});
    put(iw(OP_STORE, 4'h0, 4'h1, 4'ha, 4'h0));
    put(24'h000000);
    put({OP_CALL, 20'h00006});
    put(iw(OP_TBLRD, 4'h0, 4'h6, 4'h0, 4'h0));
    put(iw(OP_STORE, 4'h0, 4'h6, 4'ha, 4'hb));
    put({OP_GOTO, 20'h00000});
    put({OP_GOTO, 20'hfffff});
    put(24'h000000);
    put(24'h000000);
    put(iw(OP_RET, 4'h0, 4'h0, 4'h0, 4'h0));
    go();
    repeat (5) @(negedge ref_clk);
    `CHK("redirect", 23'h00000a, pm_addr)
    repeat (40) @(negedge ref_clk);
    `CHK("skipped slot", 16'h0000, `DM[8'hc0])
    `CHK("table read", 16'haaaa, `DM[8'hc1])
    `CHK("return low", 16'h000e, `DM[16'h0400])
    `CHK("return high", 16'h0000, `DM[16'h0401])
    $display("test flow done");
  endtask

  // ========================================================
  // interrupt inside repeat loop, block loop after return
  task automatic t_irq();
    int n;
    start();
    put({OP_GOTO, 20'h00005});
    put(24'h000000);
    put({OP_MOVL, 4'h9, 16'h5555});
    put(iw(OP_STORE, 4'h0, 4'h9, 4'he, 4'h0));
    put(iw(OP_RET, RET_ISR, 4'h0, 4'h0, 4'h0));
    put(24'h000000);
    put({OP_MOVL, 4'hb, 16'h0001});
    put({OP_MOVL, 4'hc, 16'h0002});
    put({OP_MOVL, 4'he, 16'h0400});
    put({OP_MOVL, 4'ha, 16'h0100});
    put({OP_REPEAT, 4'h0, 16'd20});
    put(iw(OP_ALU, ALU_ADD, 4'h1, 4'h1, 4'hb));
    put(iw(OP_STORE, 4'h0, 4'h1, 4'ha, 4'h0));
    put({OP_DO, 10'd3, 10'd1});
    put(iw(OP_ALU, ALU_ADD, 4'h2, 4'h2, 4'hb));
    put(iw(OP_STORE, 4'h0, 4'h2, 4'ha, 4'hc));
    put({OP_GOTO, 20'h00000});
    put({OP_GOTO, 20'hfffff});
    go();
    repeat (15) @(negedge ref_clk);
    irq_req = 1'b1;
    #1;
    n = 0;
    while (irq_ack !== 1'b1 && n < 30) begin
      @(negedge ref_clk);
      #1;
      n++;
    end
    `CHK("ack seen", 1'b1, irq_ack)
    `CHK("push strobe", 1'b1, dm_we)
    `CHK("push low addr", SP_RESET, dm_waddr)
    @(negedge ref_clk);
    irq_req = 1'b0;
    `CHK("push high addr", SP_RESET + WORD_STEP, dm_waddr)
    `CHK("in isr", 1'b1, in_isr)
    n = 0;
    while (in_isr !== 1'b0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("isr left", 1'b0, in_isr)
    repeat (40) @(negedge ref_clk);
    `CHK("isr store", 16'h5555, `DM[16'h0200])
    `CHK("repeat count", 16'd21, `DM[8'h80])
    `CHK("block loop", 16'd4, `DM[8'h81])
    $display("test irq done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    irq_req = 1'b0;
    t_alu();
    t_flow();
    t_irq();
    wrap_up();
  end
endmodule
`default_nettype wire
